// *** ptc_pkg.sv ***
package ptc_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses (one aligned word each)
    // ------------------------------------------------------------------
    localparam logic [7:0] PTC_OFF_CTRL0   = 8'h00;
    localparam logic [7:0] PTC_OFF_CTRL1   = 8'h04;
    localparam logic [7:0] PTC_OFF_CNT_LO  = 8'h08;
    localparam logic [7:0] PTC_OFF_CNT_HI  = 8'h0C;
    localparam logic [7:0] PTC_OFF_MA_LO   = 8'h10;
    localparam logic [7:0] PTC_OFF_MA_HI   = 8'h14;
    localparam logic [7:0] PTC_OFF_MP_LO   = 8'h18;
    localparam logic [7:0] PTC_OFF_MP_HI   = 8'h1C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int PTC_C0_HOLD   = 7;
    localparam int PTC_C0_SRC_LO = 4;
    localparam int PTC_C0_RUN    = 3;
    localparam int PTC_C1_MODE_LO = 6;
    localparam int PTC_C1_ACT_LO = 4;
    localparam int PTC_C1_LVL    = 3;
    localparam int PTC_C1_INV    = 2;
    localparam int PTC_C1_CAPTS  = 1;
    localparam int PTC_C1_CCLR   = 0;

    // ------------------------------------------------------------------
    // Reset values and widths
    // ------------------------------------------------------------------
    localparam logic [7:0]  PTC_RST_BYTE = 8'h00;
    localparam logic [9:0]  PTC_RST_CNT  = 10'h000;
    localparam logic [9:0]  PTC_CNT_MAX  = 10'h3FF;
    localparam logic [31:0] PTC_ZERO32   = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Prescaler divide counts
    // ------------------------------------------------------------------
    localparam int PTC_DIV_SYS4  = 4;
    localparam int PTC_DIV_H16   = 16;
    localparam int PTC_DIV_H64   = 64;

    // ------------------------------------------------------------------
    // Modes and tick sources
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PTC_MODE_CMP = 2'b00,
        PTC_MODE_CAP = 2'b01,
        PTC_MODE_PWM = 2'b10,
        PTC_MODE_TMR = 2'b11
    } ptc_mode_t;

    localparam logic [2:0] PTC_SRC_SYS4 = 3'b000;
    localparam logic [2:0] PTC_SRC_SYS  = 3'b001;
    localparam logic [2:0] PTC_SRC_H16  = 3'b010;
    localparam logic [2:0] PTC_SRC_H64  = 3'b011;
    localparam logic [2:0] PTC_SRC_SUB0 = 3'b100;
    localparam logic [2:0] PTC_SRC_SUB1 = 3'b101;
    localparam logic [2:0] PTC_SRC_ERIS = 3'b110;
    localparam logic [2:0] PTC_SRC_EFAL = 3'b111;

    // Bus-side state: one-hot data phase tracker
    typedef enum logic [1:0] {
        PTC_BUS_IDLE = 2'b01,
        PTC_BUS_DATA = 2'b10
    } ptc_bus_t;

    // Pending address phase
    typedef struct packed {
        logic       write;
        logic [7:0] addr;
    } ptc_req_t;

    // Pin inputs after synchronisation
    typedef struct packed {
        logic tick;
        logic cap;
        logic sub;
        logic high;
    } ptc_pins_t;

endpackage : ptc_pkg

// *** ptc_sync.sv ***
`timescale 1ns/1ps
// Three-stage synchroniser; a change is accepted once stages 2 and 3 agree
module ptc_sync
    import ptc_pkg::*;
#(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // Raw and filtered levels
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] level
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } ptc_sync_st_t;

    ptc_sync_st_t st;       // Registered state
    ptc_sync_st_t next_st;  // Next state

    // Shift and agree; stage 1 feeds only stage 2
    always_comb begin
        next_st    = st;
        next_st.s1 = raw;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) begin
                next_st.lvl[i] = st.s3[i];
            end
        end
    end

    // Register the state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.lvl;

endmodule // ptc_sync

// *** ptc_timer.sv ***
`timescale 1ns/1ps
module ptc_timer
    import ptc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Pins and slow clocks (asynchronous levels)
    input  wire logic        ext_tick_pin,
    input  wire logic        capture_pin,
    input  wire logic        high_clk,
    input  wire logic        sub_clk,
    // Waveform output pin
    output logic             wave_out_pin,
    output logic             wave_out_oe,
    // Event pulses
    output logic             match_a_event,
    output logic             match_p_event
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ptc_bus_t   bus;
        ptc_req_t   req;
        logic [31:0] rdata;
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [9:0] match_value_a;
        logic [9:0] match_value_p;
        logic [9:0] count;
        logic       run_d;
        logic [5:0] pre;
        ptc_pins_t  pins_d;
        logic       wave;
        logic       oe;
        logic       out;
        logic       ev_a;
        logic       ev_p;
    } ptc_st_t;

    ptc_st_t   st;        // Registered state
    ptc_st_t   next_st;   // Next state
    ptc_pins_t pins;      // Synchronised pin levels

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // synchroniser for the tick, capture, sub clock and high clock pins
    ptc_sync #(.WIDTH(4)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .raw     ({ext_tick_pin, capture_pin, sub_clk, high_clk}),
        .level   (pins)
    );

    // ------------------------------------------------------------------
    // Decoded fields
    // ------------------------------------------------------------------
    logic       hold;          // Count hold
    logic [2:0] tick_source_sel;
    logic       run_switch;
    ptc_mode_t  op_select;
    logic [1:0] pin_action_sel;
    logic       pin_level_sel;
    logic       pin_invert;
    logic       capture_trigger_sel;
    logic       clear_cause_sel;

    assign hold            = st.ctrl0[PTC_C0_HOLD];
    assign tick_source_sel = st.ctrl0[PTC_C0_SRC_LO +: 3];
    assign run_switch      = st.ctrl0[PTC_C0_RUN];
    assign op_select       = ptc_mode_t'(st.ctrl1[PTC_C1_MODE_LO +: 2]);
    assign pin_action_sel  = st.ctrl1[PTC_C1_ACT_LO +: 2];
    assign pin_level_sel   = st.ctrl1[PTC_C1_LVL];
    assign pin_invert      = st.ctrl1[PTC_C1_INV];
    assign capture_trigger_sel = st.ctrl1[PTC_C1_CAPTS];
    assign clear_cause_sel = st.ctrl1[PTC_C1_CCLR];

    // ------------------------------------------------------------------
    // Main logic
    // ------------------------------------------------------------------
    // Bus, registers, counter and waveform in one process
    always_comb begin
        logic       tick;       // One counting step this cycle
        logic       rise_tick;  // Tick pin edges
        logic       fall_tick;
        logic       cap_lvl;    // Selected capture source level
        logic       cap_prev;
        logic       cap_edge;   // Qualified capture event
        logic       hit_a;      // Comparator matches
        logic       hit_p;
        logic       do_clr;     // Automatic clear
        logic       p_zero;     // Period value zero: full 1024 steps
        logic       run_rise;
        logic       run_fall;
        logic       pwm_on;     // Raw PWM active phase
        logic       raw_out;    // Pin level before inversion
        logic       wr_now;     // Write data phase
        logic [7:0] wb;         // Write byte
        tick      = 1'b0;
        rise_tick = pins.tick & ~st.pins_d.tick;
        fall_tick = ~pins.tick & st.pins_d.tick;
        cap_lvl   = 1'b0;
        cap_prev  = 1'b0;
        cap_edge  = 1'b0;
        hit_a     = 1'b0;
        hit_p     = 1'b0;
        do_clr    = 1'b0;
        p_zero    = (st.match_value_p == PTC_RST_CNT);
        run_rise  = run_switch & ~st.run_d;
        run_fall  = ~run_switch & st.run_d;
        pwm_on    = 1'b0;
        raw_out   = 1'b0;
        wb        = hwdata[7:0];
        wr_now    = 1'b0;
        next_st   = st;
        next_st.pins_d = pins;
        next_st.ev_a = 1'b0;
        next_st.ev_p = 1'b0;

        // Bus data phase: complete single-cycle transfers
        wr_now = (st.bus == PTC_BUS_DATA) && st.req.write;
        if (wr_now) begin
            unique case (st.req.addr)
                PTC_OFF_CTRL0: next_st.ctrl0 = {wb[7:3], 3'b000};
                PTC_OFF_CTRL1: next_st.ctrl1 = wb;
                PTC_OFF_MA_LO: next_st.match_value_a[7:0] = wb;
                PTC_OFF_MA_HI: next_st.match_value_a[9:8] = wb[1:0];
                PTC_OFF_MP_LO: next_st.match_value_p[7:0] = wb;
                PTC_OFF_MP_HI: next_st.match_value_p[9:8] = wb[1:0];
                default: ;
            endcase
        end

        // Address phase capture; read data prepared at once
        if (hsel && hready && htrans[1]) begin
            next_st.bus       = PTC_BUS_DATA;
            next_st.req.write = hwrite;
            next_st.req.addr  = haddr[7:0];
            next_st.rdata     = PTC_ZERO32;
            if (!hwrite) begin
                // register byte; upper bits zero
                unique case (haddr[7:0])
                    PTC_OFF_CTRL0:  next_st.rdata[7:0] = st.ctrl0;
                    PTC_OFF_CTRL1:  next_st.rdata[7:0] = st.ctrl1;
                    PTC_OFF_CNT_LO: next_st.rdata[7:0] = st.count[7:0];
                    PTC_OFF_CNT_HI: next_st.rdata[1:0] = st.count[9:8];
                    PTC_OFF_MA_LO:
                        next_st.rdata[7:0] = st.match_value_a[7:0];
                    PTC_OFF_MA_HI:
                        next_st.rdata[1:0] = st.match_value_a[9:8];
                    PTC_OFF_MP_LO:
                        next_st.rdata[7:0] = st.match_value_p[7:0];
                    PTC_OFF_MP_HI:
                        next_st.rdata[1:0] = st.match_value_p[9:8];
                    default: ;
                endcase
            end
        end else if (st.bus == PTC_BUS_DATA) begin
            next_st.bus = PTC_BUS_IDLE;
        end

        // Prescaler counts system clock cycles, except with the high-clock sources
        next_st.pre = st.pre + 6'd1;

        unique case (tick_source_sel)
            PTC_SRC_SYS4: tick = (st.pre[1:0] == 2'(PTC_DIV_SYS4 - 1));
            PTC_SRC_SYS:  tick = 1'b1;
            PTC_SRC_H16:  tick = pins.high & ~st.pins_d.high &
                                 (st.pre[3:0] == 4'(PTC_DIV_H16 - 1));
            PTC_SRC_H64:  tick = pins.high & ~st.pins_d.high &
                                 (st.pre[5:0] == 6'(PTC_DIV_H64 - 1));
            PTC_SRC_SUB0,
            PTC_SRC_SUB1: tick = pins.sub & ~st.pins_d.sub;
            // one step per tick pin edge
            PTC_SRC_ERIS: tick = rise_tick;
            PTC_SRC_EFAL: tick = fall_tick;
        endcase

        // High-clock division counts high-clock edges, not system cycles
        if (tick_source_sel == PTC_SRC_H16 ||
            tick_source_sel == PTC_SRC_H64) begin
            next_st.pre = st.pre;
            if (pins.high & ~st.pins_d.high) begin
                next_st.pre = st.pre + 6'd1;
            end
            tick = pins.high & ~st.pins_d.high &
                   ((tick_source_sel == PTC_SRC_H16) ?
                    (st.pre[3:0] == 4'(PTC_DIV_H16 - 1)) :
                    (st.pre[5:0] == 6'(PTC_DIV_H64 - 1)));
        end

        // Single pulse: tick pin rising edge sets the run switch
        if (op_select == PTC_MODE_PWM && pin_action_sel == 2'b11 &&
            !run_switch && rise_tick && !wr_now) begin
            next_st.ctrl0[PTC_C0_RUN] = 1'b1;
        end

        next_st.run_d = run_switch;

        hit_a = tick && run_switch && !hold &&
                (st.count == st.match_value_a);
        hit_p = tick && run_switch && !hold &&
                (st.count == st.match_value_p);

        if (run_rise) begin
            next_st.count = PTC_RST_CNT;
        // hold stops; value kept; off keeps value
        end else if (run_switch && !hold && tick) begin
            // clear cause; only in compare and timer modes
            if (op_select == PTC_MODE_CMP || op_select == PTC_MODE_TMR) begin
                if (clear_cause_sel) begin
                    do_clr = hit_a;
                end else begin
                    // A zero period match never clears; the counter wraps
                    do_clr = (hit_p && !p_zero) ||
                             (p_zero && st.count == PTC_CNT_MAX);
                end
            end else if (op_select == PTC_MODE_PWM) begin
                do_clr = (pin_action_sel == 2'b11) ? 1'b0 : (hit_p && !p_zero);
            end else begin
                do_clr = hit_p && !p_zero;
            end
            // automatic clear on overflow or match
            if (do_clr) begin
                next_st.count = PTC_RST_CNT;
            end else begin
                next_st.count = st.count + 10'd1;
            end
        end
        if (run_fall) begin
            next_st.count = st.count;
        end

        // Event pulses; P event suppressed when A clears the counter
        next_st.ev_a = hit_a;
        next_st.ev_p = hit_p && !(clear_cause_sel &&
                       (op_select == PTC_MODE_CMP ||
                        op_select == PTC_MODE_TMR));

        cap_lvl  = capture_trigger_sel ? pins.tick : pins.cap;
        cap_prev = capture_trigger_sel ? st.pins_d.tick : st.pins_d.cap;
        unique case (pin_action_sel)
            2'b00: cap_edge = cap_lvl & ~cap_prev;
            2'b01: cap_edge = ~cap_lvl & cap_prev;
            2'b10: cap_edge = cap_lvl ^ cap_prev;
            2'b11: cap_edge = 1'b0;
        endcase
        if (op_select == PTC_MODE_CAP && run_switch && cap_edge && !wr_now)
        begin
            next_st.match_value_a = st.count;
            next_st.ev_a = 1'b1;
        end

        unique case (op_select)
            PTC_MODE_CMP: begin
                // initial level on run rising edge
                if (run_rise) begin
                    next_st.wave = pin_level_sel;
                // action on match A; same level is no change
                end else if (hit_a) begin
                    unique case (pin_action_sel)
                        2'b00: next_st.wave = st.wave;
                        2'b01: next_st.wave = 1'b0;
                        2'b10: next_st.wave = 1'b1;
                        2'b11: next_st.wave = ~st.wave;
                    endcase
                end
                raw_out = next_st.wave;
            end
            PTC_MODE_PWM: begin
                // Active while below the duty value
                if (pin_action_sel == 2'b11) begin
                    pwm_on = run_switch;
                    if (hit_a) begin
                        next_st.ctrl0[PTC_C0_RUN] = 1'b0;
                        pwm_on = 1'b0;
                    end
                end else begin
                    pwm_on = run_switch &&
                             (next_st.count < st.match_value_a);
                end
                // forced inactive, active, PWM or pulse
                unique case (pin_action_sel)
                    2'b00: pwm_on = 1'b0;
                    2'b01: pwm_on = 1'b1;
                    default: ;
                endcase
                raw_out = pin_level_sel ? pwm_on : ~pwm_on;
            end
            default: raw_out = 1'b0;
        endcase

        // output inversion; timer mode releases the pin
        next_st.oe  = (op_select != PTC_MODE_TMR);
        next_st.out = (op_select == PTC_MODE_TMR) ? 1'b0 :
                      (raw_out ^ pin_invert);
    end

    // Register all state
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st     <= '0;
            st.bus <= PTC_BUS_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign hrdata        = st.rdata;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign wave_out_pin  = st.out;
    assign wave_out_oe   = st.oe;
    assign match_a_event = st.ev_a;
    assign match_p_event = st.ev_p;

endmodule // ptc_timer

// *** ptc_pins_model.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------------
// Far side: tick and capture pins, free-running slow clocks
// ------------------------------------------------------------------
module ptc_pins_model (
    // Clock
    input  wire logic hclk,
    // Bench controls
    input  wire logic tick_go,
    input  wire logic tick_lvl,
    input  wire logic cap_lvl,
    // Pins into the timer
    output logic      ext_tick_pin,
    output logic      capture_pin,
    output logic      high_clk,
    output logic      sub_clk
);
    logic [7:0] cnt = 8'h00;  // Free divider for the slow clocks
    logic       tog = 1'b0;   // Tick pin level
    // Slow clocks never stop, so rate checks see steady edges
    assign high_clk     = cnt[2];
    assign sub_clk      = cnt[4];
    assign capture_pin  = cap_lvl;
    assign ext_tick_pin = tog;
    // Tick toggles every 8 cycles, slow enough for the synchroniser
    always @(posedge hclk) begin
        cnt <= cnt + 8'h01;
        if (!tick_go) tog <= tick_lvl;
        else if (cnt[2:0] == 3'h7) tog <= ~tog;
    end
endmodule // ptc_pins_model

// *** ptc_timer_sva.sv ***
`timescale 1ns/1ps
// Bus and pin-enable checks seen from the timer's ports
module ptc_timer_sva
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Bus
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Pin enable
    input wire logic        wave_out_oe
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       take;  // Address phase accepted
    logic       c1wr;  // Write to the second control register
    logic [7:0] ra;    // Offset being read, else unmapped
    assign take = hsel && hready && htrans[1];
    assign c1wr = take && hwrite && haddr[7:0] == PTC_OFF_CTRL1;
    assign ra   = (take && !hwrite) ? haddr[7:0] : 8'hFF;
    chk_ready_high: assert property (hreadyout)
        else $error("hreadyout dropped");
    chk_resp_okay: assert property (!hresp)
        else $error("error response given");
    chk_upper_zero: assert property (hrdata[31:8] == 24'h00_0000)
        else $error("read bits above 7 set");
    chk_high_bytes: assert property (
        (ra == PTC_OFF_CNT_HI || ra == PTC_OFF_MA_HI || ra == PTC_OFF_MP_HI)
        |=> hrdata[7:2] == 6'h00) else $error("high byte bits 7:2 set");
    chk_ctrl_low: assert property (
        ra == PTC_OFF_CTRL0 |=> hrdata[2:0] == 3'h0)
        else $error("control low bits set");
    chk_pin_released: assert property (
        c1wr ##1 hwdata[7:6] == 2'b11 |-> ##[1:3] !wave_out_oe)
        else $error("pin driven in timer mode");
    chk_pin_driven: assert property (
        c1wr ##1 !hwdata[6] |-> ##[1:3] wave_out_oe)
        else $error("pin not driven in output mode");
    chk_read_hold: assert property (
        !$past(take) && !$past(take, 2) |-> $stable(hrdata))
        else $error("read data moved without a transfer");
endmodule // ptc_timer_sva

// *** periodic_timer_control_test.sv ***
`timescale 1ns/1ps
module periodic_timer_control_test import ptc_pkg::*;;
    localparam logic [7:0] C0 = PTC_OFF_CTRL0, C1 = PTC_OFF_CTRL1;
    localparam logic [7:0] CL = PTC_OFF_CNT_LO, AL = PTC_OFF_MA_LO;
    logic        hclk = 1'b0;             // System clock
    logic        hresetn = 1'b0;          // Reset, low active
    logic [31:0] haddr = 32'h0000_0000;   // Bus address
    logic [1:0]  htrans = 2'b00;          // Transfer kind
    logic        hwrite = 1'b0;           // Write strobe
    logic [31:0] hwdata = 32'h0000_0000;  // Write data
    logic [31:0] hrdata;
    logic        hreadyout, hresp, ext_tick_pin, capture_pin;
    logic        high_clk, sub_clk, wave_out_pin, wave_out_oe;
    logic        match_a_event, match_p_event, tick_q = 1'b0;
    logic        tick_go = 1'b0, tick_lvl = 1'b0, cap_lvl = 1'b0;
    int          fail_count = 0, comparisons = 0, cyc = 0;
    int          rises = 0, falls = 0, apulse = 0, ppulse = 0;  // Tallies
    ptc_timer dut (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
        .hsize(3'b010), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .ext_tick_pin, .capture_pin, .high_clk, .sub_clk,
        .wave_out_pin, .wave_out_oe, .match_a_event, .match_p_event);
    ptc_pins_model pins (.hclk, .tick_go, .tick_lvl, .cap_lvl,
        .ext_tick_pin, .capture_pin, .high_clk, .sub_clk);
    initial forever #2 hclk = ~hclk;
    // Pin edges and match event pulses are tallied, never reset, to avoid races
    always @(posedge hclk) begin
        tick_q <= ext_tick_pin;
        if (ext_tick_pin && !tick_q) rises <= rises + 1;
        if (!ext_tick_pin && tick_q) falls <= falls + 1;
        if (match_a_event === 1'b1) apulse <= apulse + 1;
        if (match_p_event === 1'b1) ppulse <= ppulse + 1;
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            fail_count++;
            stop_test();
        end
    end
    task automatic stop_test();
        if (fail_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [7:0] e, g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    // One single transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        @(posedge hclk);
        htrans <= 2'b10;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= {24'h00_0000, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata[7:0];
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask
    task automatic t_regs();
        logic [7:0] q;
        logic [7:0] ex [8] = '{8'hF0, 8'hF7, 8'h00, 8'h00,
                               8'hF7, 8'h03, 8'hF7, 8'h03};
        for (int i = 0; i < 8; i++) begin
            rd(8'(4 * i), q);
            cmp("reset value", 8'h00, q);
            wr(8'(4 * i), 8'hF7);
            rd(8'(4 * i), q);
            cmp("written value", ex[i], q);
        end
        wr(8'h20, 8'hFF);
        rd(8'h20, q);
        cmp("unmapped", 8'h00, q);
        for (int i = 0; i < 8; i++) wr(8'(4 * i), 8'h00);
    endtask
    task automatic t_run();
        logic [7:0] c1, c2, c3;
        wr(C1, 8'hC0);
        wr(C0, 8'h18);
        repeat (20) @(posedge hclk);
        wr(C0, 8'h98);
        rd(CL, c1);
        repeat (10) @(posedge hclk);
        rd(CL, c2);
        cmp("held count", c1, c2);
        wr(C0, 8'h18);
        repeat (10) @(posedge hclk);
        rd(CL, c3);
        cmp("resumed", 8'h01, 8'(c3 > c1 && c3 < c1 + 40));
        wr(C0, 8'h10);
        rd(CL, c1);
        repeat (10) @(posedge hclk);
        rd(CL, c2);
        cmp("stopped count", c1, c2);
        wr(C0, 8'h18);
        rd(CL, c3);
        cmp("restart", 8'h01, 8'(c3 < 12 && c1 > 30));
    endtask
    task automatic t_src();
        logic [7:0] c;
        int         e [6] = '{36, 143, 1, 0, 4, 4};
        int         r;
        for (int s = 0; s < 8; s++) begin
            wr(C0, 8'h00);
            wr(C0, 8'(s * 16 + 8));
            r = (s == 6) ? rises : falls;
            tick_go <= (s > 5);
            repeat (128) @(posedge hclk);
            tick_go <= 1'b0;
            repeat (12) @(posedge hclk);
            rd(CL, c);
            if (s > 5)
                cmp("pin ticks", 8'((s == 6 ? rises : falls) - r), c);
            else
                cmp("rate", 8'h01, 8'(c + 3 >= e[s] && c <= e[s] + 3));
        end
    endtask
    // Output unit is always stopped before its mode or action changes
    task automatic t_cmp();
        logic [1:0] act;
        logic       lvl, inv, e;
        wr(AL, 8'h05);
        for (int k = 0; k < 16; k++) begin
            act = 2'(k);
            lvl = k[2];
            inv = k[3];
            e = (act == 2'b00) ? lvl : (act == 2'b11) ? ~lvl : act[1];
            wr(C0, 8'h00);
            wr(C1, {2'b00, act, lvl, inv, 2'b00});
            wr(C0, 8'h08);
            repeat (4) @(posedge hclk);
            cmp("initial level", 8'(lvl ^ inv), 8'(wave_out_pin));
            cmp("driven", 8'h01, 8'(wave_out_oe));
            repeat (40) @(posedge hclk);
            cmp("after match", 8'(e ^ inv), 8'(wave_out_pin));
        end
        for (int k = 0; k < 2; k++) begin
            wr(C0, 8'h00);
            wr(C1, k ? 8'h98 : 8'h88);
            wr(C0, 8'h08);
            repeat (6) @(posedge hclk);
            cmp("forced level", 8'(k), 8'(wave_out_pin));
        end
        wr(C0, 8'h00);
        wr(C1, 8'hC0);
        repeat (4) @(posedge hclk);
        cmp("released", 8'h00, 8'(wave_out_oe));
    endtask
    task automatic t_cap();
        logic [7:0] e [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
        int         a;
        for (int k = 0; k < 4; k++) begin
            wr(C0, 8'h00);
            wr(AL, 8'hFF);
            wr(PTC_OFF_MA_HI, 8'h03);
            wr(C1, {2'b01, 2'(k), 2'b00, k[0], 1'b0});
            wr(C0, 8'h18);
            a = apulse;
            if (k[0]) tick_lvl <= 1'b1; else cap_lvl <= 1'b1;
            repeat (12) @(posedge hclk);
            if (k[0]) cap_lvl <= 1'b1; else tick_lvl <= 1'b1;
            repeat (12) @(posedge hclk);
            tick_lvl <= 1'b0;
            cap_lvl <= 1'b0;
            repeat (12) @(posedge hclk);
            cmp("captures", e[k], 8'(apulse - a));
        end
    endtask
    task automatic t_clr();
        logic [7:0] c, mx;
        int         b, p;
        wr(AL, 8'h09);
        wr(PTC_OFF_MA_HI, 8'h00);
        wr(PTC_OFF_MP_LO, 8'h0C);
        for (int k = 0; k < 2; k++) begin
            b = k ? 9 : 12;
            mx = 8'h00;
            wr(C0, 8'h00);
            wr(C1, {7'h60, k[0]});
            wr(C0, 8'h18);
            p = ppulse;
            repeat (20) begin
                rd(CL, c);
                if (c > mx) mx = c;
            end
            cmp("wrap point", 8'h01, 8'(mx + 1 >= b && mx <= b));
            cmp("p events", 8'(!k), 8'(ppulse > p));
        end
    endtask
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_run();
        t_src();
        t_cmp();
        t_cap();
        t_clr();
        stop_test();
    end
endmodule // periodic_timer_control_test
bind ptc_timer ptc_timer_sva chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .wave_out_oe);
